// ### src/stpc_timer.sv
// Standard timer with single-pulse output and capture input modes behind AXI4-Lite.
//
// Functional notes
// R01 - Pulse mode needs mode 10 and pin function 11, left unchanged.
// R02 - Run rising starts the counter and the pulse leading edge.
// R03 - In pulse mode a trigger pin edge sets the run bit.
// R04 - Pulse trailing edge follows run falling, by software or match.
// R05 - In pulse mode a match A clears the run bit.
// R06 - In pulse mode a match A raises the interrupt request.
// R07 - In pulse mode only run rising clears the counter.
// R08 - Pulse mode ignores compare-P, clear-source and swap.
// R09 - Software holds the run bit high for the whole pulse; here the trigger pin can also set it and match A clears it.
// R10 - Capture mode is mode 01; run rising starts the counter.
// R11 - A selected capture edge copies the counter into compare-A and requests.
// R12 - In capture mode the counter runs until run falls.
// R13 - In capture mode a match P zeroes the counter and requests.
// R14 - In capture mode compare-P of zero gives the full range.
// R15 - Pin function 11 in capture mode disables capture only.
// R16 - Capture pulses under two timer periods may be missed.
// R17 - Match-A flag sets half a timer period after a capture.
// R18 - Capture latches under 1.5 timer periods after the edge.
// R19 - Capture mode drives no output and ignores output bits.
// R20 - Capture mode needs an available timer clock.
// R21 - Counter and compare registers are 10 or 16 bits wide.
// R22 - Run rising sets the output to the initial level.
// R23 - The invert bit inverts the output waveform.
// R24 - Capture edge: pin function 00 rising, 01 falling, 10 both.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "stpc_consts.svh"

module stpc_timer #(
   parameter int CNT_W = 16
) (
   // Clock and reset.
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output      logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output      logic        S_AXI_WREADY,
   // AXI4-Lite write response.
   output      logic [1:0]  S_AXI_BRESP,
   output      logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read.
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output      logic        S_AXI_ARREADY,
   output      logic [31:0] S_AXI_RDATA,
   output      logic [1:0]  S_AXI_RRESP,
   output      logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Timer pins.
   input  wire logic        EXT_TIMER_CLOCK_PIN,
   input  wire logic        CAPTURE_INPUT_PIN,
   output      logic        TIMER_OUTPUT_PIN,
   output      logic        TIMER_OUTPUT_EN,
   // Interrupt request levels from the sticky match flags.
   output      logic        MATCH_A_REQ,
   output      logic        MATCH_P_REQ
);

   // Only the two documented widths are built.
   initial begin
      if (CNT_W != 10 && CNT_W != 16) begin // R21
         $error("CNT_W must be 10 or 16");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   stpc_pkg::stpc_ctrl_t  ctrl_reg;
   stpc_pkg::stpc_flags_t flags_reg;
   logic [15:0]           prescale_reg;
   logic [CNT_W-1:0]      cmpa_reg;
   logic [CNT_W-1:0]      cmpp_reg;
   logic [CNT_W-1:0]      count_reg;
   logic                  run_prev_reg;
   logic [15:0]           div_cnt_reg;
   logic                  phase_reg;
   logic [1:0]            trig_sync_reg;
   logic                  trig_last_reg;
   logic [1:0]            cap_sync_reg;
   logic                  cap_last_reg;
   logic                  cap_pend_reg;
   logic                  cap_flag_pend_reg;
   logic                  out_level_reg;
   logic                  aw_full_reg;
   logic [7:0]            aw_addr_reg;
   logic                  w_full_reg;
   logic [31:0]           w_data_reg;
   logic [3:0]            w_strb_reg;
   logic                  bvalid_reg;
   logic [1:0]            bresp_reg;
   logic                  rvalid_reg;
   logic [31:0]           rdata_reg;
   logic [1:0]            rresp_reg;

   logic                  pulse_mode;
   logic                  cap_mode;
   logic                  run_rise;
   logic                  tick_rise;
   logic                  tick_fall;
   logic                  trig_edge;
   logic                  cap_edge;
   logic                  match_a;
   logic                  match_p;
   logic                  cap_take;
   logic                  wr_do;
   logic                  wr_ctrl;
   logic                  wr_stat;
   logic [31:0]           ctrl_word;
   logic [31:0]           wr_merged;
   stpc_pkg::stpc_flags_t flag_set;
   stpc_pkg::stpc_flags_t flag_clr;

   // Merges the written bytes over the present register word.
   function automatic logic [31:0] stpc_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_word;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return res;
   endfunction : stpc_merge

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Mode decode; pulse mode also needs pin function 11, as software must program it.
   assign pulse_mode = (ctrl_reg.mode_select == stpc_pkg::STPC_MODE_PULSE)
                       && (ctrl_reg.pin_function == 2'h3); // R01
   assign cap_mode   = (ctrl_reg.mode_select == stpc_pkg::STPC_MODE_CAPTURE); // R10
   assign run_rise   = ctrl_reg.counter_run_bit && !run_prev_reg;
   assign ctrl_word  = {{(32 - `STPC_CTRL_WIDTH){1'b0}}, ctrl_reg};

   // Timer clock: a half period is PRESCALE+1 sys clocks, so the half-period points exist.
   assign tick_rise  = (div_cnt_reg == prescale_reg) && !phase_reg;
   assign tick_fall  = (div_cnt_reg == prescale_reg) && phase_reg;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         div_cnt_reg <= 16'h0000;
         phase_reg   <= 1'b0;
      end else if (div_cnt_reg == prescale_reg) begin
         div_cnt_reg <= 16'h0000;
         phase_reg   <= !phase_reg;
      end else begin
         div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Pin synchronisers; only the second stage feeds the edge detectors.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         trig_sync_reg <= 2'h0;
         trig_last_reg <= 1'b0;
         cap_sync_reg  <= 2'h0;
         cap_last_reg  <= 1'b0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[0], EXT_TIMER_CLOCK_PIN};
         trig_last_reg <= trig_sync_reg[1];
         cap_sync_reg  <= {cap_sync_reg[0], CAPTURE_INPUT_PIN};
         cap_last_reg  <= cap_sync_reg[1];
      end
   end

   // Trigger pin active edge is its rising edge.
   assign trig_edge = trig_sync_reg[1] && !trig_last_reg;

   // Capture edge selection; code 11 never captures.
   always_comb begin
      unique case (ctrl_reg.pin_function) // R24
         2'h0:    cap_edge = cap_sync_reg[1] && !cap_last_reg;
         2'h1:    cap_edge = !cap_sync_reg[1] && cap_last_reg;
         2'h2:    cap_edge = cap_sync_reg[1] != cap_last_reg;
         default: cap_edge = 1'b0; // R15
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Comparators are evaluated on the timer clock's rising point only.
   assign match_a  = tick_rise && pulse_mode && ctrl_reg.counter_run_bit
                     && (count_reg == cmpa_reg); // R05
   assign match_p  = tick_rise && cap_mode && ctrl_reg.counter_run_bit // R08
                     && (((cmpp_reg != '0) && (count_reg == cmpp_reg))
                         || ((cmpp_reg == '0) && (count_reg == '1))); // R13 R14
   // An edge waits at most one timer period for the next rising point, plus two sync clocks.
   assign cap_take = tick_rise && cap_mode && (cap_pend_reg || cap_edge); // R18

   // Counter: cleared on run rising, advanced on timer ticks while running.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         count_reg <= '0;
      end else if (run_rise && (pulse_mode || cap_mode)) begin
         count_reg <= '0; // R07 R02 R10
      end else if (match_p) begin
         count_reg <= '0; // R13
      end else if (tick_rise && ctrl_reg.counter_run_bit && !match_a
                   && (pulse_mode || cap_mode)) begin
         count_reg <= count_reg + 1'b1; // R12 R14
      end
   end

   // Run edge memory for the rising-edge detector.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         run_prev_reg <= 1'b0;
      end else begin
         run_prev_reg <= ctrl_reg.counter_run_bit;
      end
   end

   // Edges seen between timer ticks are held so short pulses are still caught if possible.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cap_pend_reg <= 1'b0;
      end else if (!cap_mode || cap_take) begin
         cap_pend_reg <= 1'b0;
      end else if (cap_edge) begin
         cap_pend_reg <= 1'b1; // R16
      end
   end

   // Flag for a capture follows the latch by half a timer period.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cap_flag_pend_reg <= 1'b0;
      end else if (cap_take) begin
         cap_flag_pend_reg <= 1'b1;
      end else if (tick_fall) begin
         cap_flag_pend_reg <= 1'b0; // R17
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Output level: initial level at run rising, inactive level once run falls.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         out_level_reg <= 1'b0;
      end else if (run_rise) begin
         out_level_reg <= ctrl_reg.output_initial_level; // R22 R02
      end else if (!ctrl_reg.counter_run_bit) begin
         out_level_reg <= !ctrl_reg.output_initial_level; // R04
      end
   end

   // Only pulse mode drives the pin; capture mode has no output function.
   assign TIMER_OUTPUT_PIN = pulse_mode && (out_level_reg ^ ctrl_reg.output_invert); // R23 R19
   assign TIMER_OUTPUT_EN  = pulse_mode; // R19

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Write handshake: address and data are taken in either order, then one response.
   assign wr_do   = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_ctrl = wr_do && (aw_addr_reg == `STPC_OFF_CTRL);
   assign wr_stat = wr_do && (aw_addr_reg == `STPC_OFF_STATUS);
   assign S_AXI_AWREADY = !aw_full_reg;
   assign S_AXI_WREADY  = !w_full_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (S_AXI_AWVALID && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= S_AXI_AWADDR;
      end else if (wr_do) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (S_AXI_WVALID && !w_full_reg) begin
         w_full_reg <= 1'b1;
         w_data_reg <= S_AXI_WDATA;
         w_strb_reg <= S_AXI_WSTRB;
      end else if (wr_do) begin
         w_full_reg <= 1'b0;
      end
   end

   // Response: unmapped or read-only offsets answer SLVERR and change nothing.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `STPC_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_reg <= 1'b1;
         unique case (aw_addr_reg)
            `STPC_OFF_CTRL, `STPC_OFF_PRESCALE, `STPC_OFF_CMPA,
            `STPC_OFF_CMPP, `STPC_OFF_STATUS: bresp_reg <= `STPC_RESP_OKAY;
            default:                          bresp_reg <= `STPC_RESP_SLVERR;
         endcase
      end else if (S_AXI_BREADY) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_comb begin
      unique case (aw_addr_reg)
         `STPC_OFF_CTRL:     wr_merged = stpc_merge(ctrl_word, w_data_reg, w_strb_reg);
         `STPC_OFF_PRESCALE: wr_merged = stpc_merge({16'h0000, prescale_reg},
                                                    w_data_reg, w_strb_reg);
         `STPC_OFF_CMPA:     wr_merged = stpc_merge(32'(cmpa_reg), w_data_reg, w_strb_reg);
         `STPC_OFF_CMPP:     wr_merged = stpc_merge(32'(cmpp_reg), w_data_reg, w_strb_reg);
         default:            wr_merged = w_data_reg & {28'h0000000, {4{w_strb_reg[0]}}};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Control: software writes, the trigger pin sets run, a match A clears it.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ctrl_reg <= stpc_pkg::stpc_ctrl_t'(`STPC_RST_CTRL);
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= stpc_pkg::stpc_ctrl_t'(wr_merged[`STPC_CTRL_WIDTH-1:0]);
         end
         if (pulse_mode && trig_edge) begin
            ctrl_reg.counter_run_bit <= 1'b1; // R03
         end
         if (match_a) begin
            ctrl_reg.counter_run_bit <= 1'b0; // R05 R04
         end
      end
   end

   // Prescale and compare-P are plain software registers.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         prescale_reg <= `STPC_RST_PRESCALE;
         cmpp_reg     <= CNT_W'(`STPC_RST_CMP);
      end else if (wr_do) begin
         if (aw_addr_reg == `STPC_OFF_PRESCALE) begin
            prescale_reg <= wr_merged[15:0];
         end
         if (aw_addr_reg == `STPC_OFF_CMPP) begin
            cmpp_reg <= wr_merged[CNT_W-1:0];
         end
      end
   end

   // Compare-A: a capture overrides a software write in the same cycle.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cmpa_reg <= CNT_W'(`STPC_RST_CMP);
      end else if (cap_take) begin
         cmpa_reg <= count_reg; // R11
      end else if (wr_do && (aw_addr_reg == `STPC_OFF_CMPA)) begin
         cmpa_reg <= wr_merged[CNT_W-1:0];
      end
   end

   // Sticky flags, write one to clear; a set in the clearing cycle wins.
   assign flag_set.match_a_flag = match_a || (cap_flag_pend_reg && tick_fall); // R06 R11 R17
   assign flag_set.match_p_flag = match_p; // R13
   assign flag_clr = wr_stat ? stpc_pkg::stpc_flags_t'(wr_merged[1:0])
                             : stpc_pkg::stpc_flags_t'(2'h0);

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         flags_reg <= stpc_pkg::stpc_flags_t'(2'h0);
      end else begin
         flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      end
   end

   assign MATCH_A_REQ = flags_reg.match_a_flag;
   assign MATCH_P_REQ = flags_reg.match_p_flag;

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Read channel: one cycle from address to data, held until taken.
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= `STPC_RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= `STPC_RESP_OKAY;
         unique case (S_AXI_ARADDR)
            `STPC_OFF_CTRL:     rdata_reg <= ctrl_word;
            `STPC_OFF_PRESCALE: rdata_reg <= {16'h0000, prescale_reg};
            `STPC_OFF_CMPA:     rdata_reg <= 32'(cmpa_reg);
            `STPC_OFF_CMPP:     rdata_reg <= 32'(cmpp_reg);
            `STPC_OFF_COUNT:    rdata_reg <= 32'(count_reg);
            `STPC_OFF_STATUS:   rdata_reg <= {30'h00000000, flags_reg};
            default: begin
               rdata_reg <= 32'h00000000;
               rresp_reg <= `STPC_RESP_SLVERR;
            end
         endcase
      end else if (S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule : stpc_timer

// ### include/stpc_consts.svh
// Offsets, field positions, reset values and bus answer codes of the pulse/capture timer.
`ifndef STPC_CONSTS_SVH
`define STPC_CONSTS_SVH

// Register byte offsets on the register bus.
`define STPC_OFF_CTRL      8'h00
`define STPC_OFF_PRESCALE  8'h04
`define STPC_OFF_CMPA      8'h08
`define STPC_OFF_CMPP      8'h0C
`define STPC_OFF_COUNT     8'h10
`define STPC_OFF_STATUS    8'h14

// Control register field positions.
`define STPC_CTRL_RUN      0
`define STPC_CTRL_MODE_LO  4
`define STPC_CTRL_MODE_HI  5
`define STPC_CTRL_PIN_LO   6
`define STPC_CTRL_PIN_HI   7
`define STPC_CTRL_INIT     8
`define STPC_CTRL_INV      9
`define STPC_CTRL_CCLR     10
`define STPC_CTRL_DPX      11
`define STPC_CTRL_WIDTH    12

// Status register field positions.
`define STPC_STAT_MATCH_A  0
`define STPC_STAT_MATCH_P  1

// Reset values.
`define STPC_RST_CTRL      12'h000
`define STPC_RST_PRESCALE  16'h0000
`define STPC_RST_CMP       16'h0000

// Bus answer codes.
`define STPC_RESP_OKAY     2'h0
`define STPC_RESP_SLVERR   2'h2

`endif

// ### include/stpc_pkg.sv
// Types shared by the pulse/capture timer design.
package stpc_pkg;

   // Operating mode selection codes.
   typedef enum logic [1:0] {
      STPC_MODE_COMPARE = 2'h0,
      STPC_MODE_CAPTURE = 2'h1,
      STPC_MODE_PULSE   = 2'h2,
      STPC_MODE_TIMER   = 2'h3
   } stpc_mode_t;

   // Control fields as held in the control register.
   typedef struct packed {
      logic       period_duty_swap;
      logic       clear_source_select;
      logic       output_invert;
      logic       output_initial_level;
      logic [1:0] pin_function;
      stpc_mode_t mode_select;
      logic [2:0] spare;
      logic       counter_run_bit;
   } stpc_ctrl_t;

   // Sticky event flags.
   typedef struct packed {
      logic match_p_flag;
      logic match_a_flag;
   } stpc_flags_t;

endpackage : stpc_pkg

// ### bench/stpc_timer_props.sv
// Concurrent checks on the bus and pin ports of the pulse/capture timer.
`timescale 1ns/100ps
module stpc_timer_props (
   // Clock and reset.
   input wire logic        CLK_SYS,
   input wire logic        SYS_RST,
   // Register bus.
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   // Timer pins and requests.
   input wire logic        TIMER_OUTPUT_PIN,
   input wire logic        TIMER_OUTPUT_EN,
   input wire logic        MATCH_A_REQ,
   input wire logic        MATCH_P_REQ
);
   // One domain: one default clock and reset.
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   ////////////////////////////////////////////////////////////////////////////////
   // Answers hold until taken; a read is refused while one is pending.
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
   a_read_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while answer pending");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");

   ////////////////////////////////////////////////////////////////////////////////
   // Pin and request behaviour.
   a_pin_idle: assert property (!TIMER_OUTPUT_EN |-> !TIMER_OUTPUT_PIN)
      else $error("output driven outside pulse mode");
   a_pulse_trail: assert property ($rose(MATCH_A_REQ) && TIMER_OUTPUT_EN
      |-> ##[0:2] $changed(TIMER_OUTPUT_PIN)) else $error("no trailing edge on match");
   a_en_by_write: assert property ($changed(TIMER_OUTPUT_EN) && !$past(SYS_RST)
      |-> S_AXI_BVALID) else $error("output enable moved without a write");
   a_flag_a_held: assert property ($fell(MATCH_A_REQ) && !$past(SYS_RST)
      |-> S_AXI_BVALID) else $error("match A request lost");
   a_flag_p_held: assert property ($fell(MATCH_P_REQ) && !$past(SYS_RST)
      |-> S_AXI_BVALID) else $error("match P request lost");
endmodule : stpc_timer_props

bind stpc_timer stpc_timer_props u_props (.*);

// ### bench/stpc_pin_source.sv
// Trigger and capture signal sources that stand outside the timer.
`timescale 1ns/100ps
module stpc_pin_source (
   // Pacing clock.
   input  wire logic clk,
   // Pins into the timer.
   output logic      trig_pin,
   output logic      cap_pin
);
   // Both pins rest low between events.
   initial begin
      trig_pin = 1'b0;
      cap_pin  = 1'b0;
   end
   // One rising trigger edge, held well past the input synchroniser.
   task automatic trigger();
      @(posedge clk) trig_pin <= 1'b1;
      repeat (8) @(posedge clk);
      trig_pin <= 1'b0;
   endtask : trigger
   // Each level lasts longer than two timer periods, since shorter ones may be lost.
   task automatic cap_pulse(input int hold);
      @(posedge clk) cap_pin <= 1'b1;
      repeat (hold) @(posedge clk);
      cap_pin <= 1'b0;
      repeat (hold) @(posedge clk);
   endtask : cap_pulse
endmodule : stpc_pin_source

// ### bench/testbench.sv
// Register-level tests of the pulse/capture timer.
`timescale 1ns/100ps
`include "stpc_consts.svh"
module testbench;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_v, c1;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic        awready, wready, bvalid, arready, rvalid, trig, cap, pin, pin_en, req_a, req_p;
   int          error_cnt, n_compared;

   // The 10-bit width keeps a full-range wrap short enough to watch.
   stpc_timer #(.CNT_W(10)) dut (.CLK_SYS(clk), .SYS_RST(rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .EXT_TIMER_CLOCK_PIN(trig), .CAPTURE_INPUT_PIN(cap), .TIMER_OUTPUT_PIN(pin),
      .TIMER_OUTPUT_EN(pin_en), .MATCH_A_REQ(req_a), .MATCH_P_REQ(req_p));
   stpc_pin_source src (.clk(clk), .trig_pin(trig), .cap_pin(cap));

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks.
   task automatic close_out();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Outputs are sampled 1 ns after an edge; each valid drops at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      logic       ha, hw, hb;
      {r, hb} = 3'h2;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      for (int i = 0; i < 100 && !hb; i++) begin
         #1 {ha, hw, hb} = {awready, wready, bvalid};
         if (hb) r = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk("write_resp", 32'(er), 32'(r));
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, hr;
      {d, r, hr} = 35'h2;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      for (int i = 0; i < 100 && !hr; i++) begin
         #1 {ha, hr} = {arready, rvalid};
         if (hr) {d, r} = {rdata, rresp};
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
      end
      if (!hr) error_cnt++;
      rready <= 1'b0;
   endtask : rd
   // Bounded wait on a request line.
   task automatic wait_req(input int lim, input logic p_side);
      for (int i = 0; i < lim && !(p_side ? req_p : req_a); i++) @(posedge clk);
   endtask : wait_req

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end

   // Main sequence.
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(`STPC_OFF_CTRL, rd_v, rs);
      chk("ctrl_reset", 32'h0, rd_v);
      rd(8'h1C, rd_v, rs);
      chk("unmapped", 32'(`STPC_RESP_SLVERR), 32'(rs));
      wr(`STPC_OFF_COUNT, 32'h7, `STPC_RESP_SLVERR);
      // Software pulse; compare P, clear-source and swap set.
      wr(`STPC_OFF_CMPP, 32'h2, `STPC_RESP_OKAY);
      wr(`STPC_OFF_CMPA, 32'h5, `STPC_RESP_OKAY);
      wr(`STPC_OFF_CTRL, 32'hCE0, `STPC_RESP_OKAY);
      chk("out_enable", 32'h1, 32'(pin_en));
      wr(`STPC_OFF_CTRL, 32'hDE1, `STPC_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("pulse_lead", 32'h1, 32'(pin));
      wait_req(100, 1'b0);
      chk("match_a", 32'h1, 32'(req_a));
      repeat (3) @(posedge clk);
      chk("pulse_trail", 32'h0, 32'(pin));
      rd(`STPC_OFF_CTRL, rd_v, rs);
      chk("run_cleared", 32'hDE0, rd_v);
      rd(`STPC_OFF_COUNT, rd_v, rs);
      chk("count_held", 32'h5, rd_v);
      wr(`STPC_OFF_STATUS, 32'h3, `STPC_RESP_OKAY);
      chk("flag_cleared", 32'h0, 32'(req_a));
      // Pulse started by the trigger pin, with the output inverted.
      wr(`STPC_OFF_CTRL, 32'hFE0, `STPC_RESP_OKAY);
      src.trigger();
      chk("pin_inverted", 32'h0, 32'(pin));
      wait_req(100, 1'b0);
      chk("trig_match", 32'h1, 32'(req_a));
      repeat (3) @(posedge clk);
      chk("trig_trail", 32'h1, 32'(pin));
      rd(`STPC_OFF_CTRL, rd_v, rs);
      chk("trig_run", 32'hFE0, rd_v);
      // Capture with every edge choice; choice 11 captures nothing.
      wr(`STPC_OFF_CMPP, 32'h40, `STPC_RESP_OKAY);
      for (int p = 0; p < 4; p++) begin
         wr(`STPC_OFF_CTRL, {24'h0, 2'(p), 6'h10}, `STPC_RESP_OKAY);
         wr(`STPC_OFF_CMPA, 32'hFFFF, `STPC_RESP_OKAY);
         wr(`STPC_OFF_STATUS, 32'h3, `STPC_RESP_OKAY);
         wr(`STPC_OFF_CTRL, {24'h0, 2'(p), 6'h11}, `STPC_RESP_OKAY);
         src.cap_pulse(6);
         repeat (6) @(posedge clk);
         chk("cap_flag", 32'(p != 3), 32'(req_a));
         rd(`STPC_OFF_CMPA, rd_v, rs);
         chk("cap_kept", 32'(p == 3), 32'(rd_v == 32'h3FF));
         chk("no_output", 32'h0, 32'(pin_en));
      end
      wait_req(200, 1'b1);
      chk("wrap_p", 32'h1, 32'(req_p));
      // Compare P of zero gives the full range.
      wr(`STPC_OFF_CTRL, 32'hD0, `STPC_RESP_OKAY);
      wr(`STPC_OFF_CMPP, 32'h0, `STPC_RESP_OKAY);
      wr(`STPC_OFF_STATUS, 32'h3, `STPC_RESP_OKAY);
      wr(`STPC_OFF_CTRL, 32'hD1, `STPC_RESP_OKAY);
      rd(`STPC_OFF_COUNT, c1, rs);
      repeat (19) @(posedge clk);
      rd(`STPC_OFF_COUNT, rd_v, rs);
      chk("count_rate", 32'hB, rd_v - c1);
      repeat (1800) @(posedge clk);
      chk("no_early_wrap", 32'h0, 32'(req_p));
      wait_req(600, 1'b1);
      chk("full_wrap", 32'h1, 32'(req_p));
      close_out();
   end
endmodule : testbench
